/* File: design/cfr_pkg.sv */
// package: constants and types of the cpu core datapath
package cfr_pkg;
    // ------------------------------------------------------------
    // sizes and data-space map
    // ------------------------------------------------------------
    localparam int PC_W = 15;
    localparam int NREG = 32;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] XIO_BASE = 16'h0060;
    localparam logic [15:0] A_STK_LO = 16'h005D;
    localparam logic [15:0] A_STK_HI = 16'h005E;
    localparam logic [15:0] A_FLAGS = 16'h005F;
    localparam logic [4:0] PTR_BASE = 5'h1A;
    localparam logic [4:0] PTR_Z = 5'h1E;
    localparam logic [4:0] PAIR_MUL = 5'h00;
    // ------------------------------------------------------------
    // reset values and flag positions
    // ------------------------------------------------------------
    localparam logic [15:0] STK_RST = 16'h0000;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam int F_I = 7;
    localparam int F_T = 6;
    localparam int F_H = 5;
    localparam int F_S = 4;
    localparam int F_V = 3;
    localparam int F_N = 2;
    localparam int F_Z = 1;
    localparam int F_C = 0;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
        OP_MOV, OP_LDI, OP_MOVW, OP_ADIW, OP_MUL, OP_BIT_STORE,
        OP_BIT_LOAD, OP_IRQ_ENABLE, OP_IRQ_DISABLE, OP_LD, OP_ST,
        OP_LDS, OP_STS, OP_IN, OP_OUT, OP_PUSH, OP_POP, OP_CALL,
        OP_SUB_RETURN, OP_IRQ_RETURN, OP_JMP, OP_LPM
    } cfr_op_t;
    typedef enum logic [1:0] {AM_DISP, AM_POSTINC, AM_PREDEC} cfr_am_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'h0, ST_MEM = 3'h1, ST_PUSH = 3'h3,
        ST_POP1 = 3'h2, ST_POP2 = 3'h6, ST_LPM = 3'h7
    } cfr_st_t;
    typedef struct packed {
        cfr_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [1:0] ptr;
        cfr_am_t am;
        logic [15:0] imm;
    } cfr_uop_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } cfr_dm_t;
endpackage : cfr_pkg

/* File: design/cfr_core.sv */
// cpu core datapath: fetch overlap, register file, flags, stack pointer
`timescale 1ns/100ps
// Operation
// RL1 - fetch next instruction while current executes
// RL2 - thirty-two byte registers, single-cycle access
// RL3 - read two operands, compute, write back
// RL4 - register file 8/16-bit read and write schemes
// RL5 - top six registers form three pointers
// RL6 - pointers: displacement, post-increment, pre-decrement
// RL7 - registers mapped at data addresses 0-31
// RL8 - i/o space mapped right after registers
// RL9 - extended i/o only through data-space access
// RL10 - global enable clear blocks every interrupt
// RL11 - enable cleared on entry, set on return
// RL12 - bit 6 copy bit for bit store/load
// RL13 - bit 5 carries out of low nibble
// RL14 - bit 4 equals negative xor overflow
// RL15 - bit 3 overflow, bit 2 negative
// RL16 - bit 1 zero, bit 0 carry
// RL17 - flags updated after every alu operation
// RL18 - flags never saved or restored by hardware
// RL19 - stack grows downward, pointer marks top
// RL20 - stack pointer steps by one or two
// RL21 - two byte stack pointer registers, reset zero
// RL22 - software puts stack above 0x100 first
// RL23 - interrupt return takes four clock cycles
// RL24 - flags reset to zero, interrupts off
module cfr_core
    import cfr_pkg::*;
(
    input logic REF_CLK,
    input logic NRST,
    output logic [PC_W-1:0] PM_ADDR,
    input logic [15:0] PM_DATA,
    output logic [15:0] INSTR,
    output logic INSTR_VALID,
    input cfr_uop_t UOP,
    output cfr_dm_t DM_REQ,
    input logic [7:0] DM_RDATA,
    input logic IRQ_REQ,
    input logic [PC_W-1:0] IRQ_VEC,
    output logic IRQ_ACK,
    output logic [7:0] FLAGS,
    output logic [15:0] STACK_PTR
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] rf [NREG];
    cfr_st_t st, next_st;
    logic [PC_W-1:0] pc, pm_addr, ir_pc, ret_pc, tgt;
    logic [15:0] ir, stk_ptr, next_stk;
    logic [7:0] flags, next_flags, pop_hi;
    logic ir_valid, irq_ack, mem_ld, lpm_odd, ret_irq, hold;
    logic [4:0] mem_reg;
    cfr_dm_t dm, next_dm;
    cfr_op_t op;

    function automatic logic int_addr(input logic [15:0] a);
        int_addr = a < IO_BASE || a == A_STK_LO || a == A_STK_HI ||
            a == A_FLAGS;
    endfunction : int_addr

    // ------------------------------------------------------------
    // issue and operand read
    // ------------------------------------------------------------
    wire run = st == ST_RUN && ir_valid;
    // irq preempts the queued instruction; one instruction after enable
    wire take_irq = run && IRQ_REQ && flags[F_I] && !hold; // [RL10]
    wire exec = run && !take_irq;
    assign op = exec ? UOP.op : OP_NOP;
    wire [7:0] ra = rf[UOP.rd];
    wire [7:0] rb = rf[UOP.rr];
    wire [4:0] pa = {UOP.rd[4:1], 1'b0};
    wire [4:0] pb = {UOP.rr[4:1], 1'b0};
    wire [15:0] wa = {rf[pa | 5'h01], rf[pa]};
    wire [15:0] wb = {rf[pb | 5'h01], rf[pb]};
    wire [4:0] pl = PTR_BASE + {2'h0, UOP.ptr, 1'b0}; // [RL5]
    wire [15:0] ptr_val = {rf[pl | 5'h01], rf[pl]};
    wire [15:0] zptr = {rf[PTR_Z | 5'h01], rf[PTR_Z]}; // [RL5]
    wire bst_bit = ra[UOP.imm[2:0]];

    // ------------------------------------------------------------
    // alu
    // ------------------------------------------------------------
    wire is_sub = op == OP_SUB || op == OP_SBC;
    wire is_arith = op == OP_ADD || op == OP_ADC || is_sub;
    wire is_logic = op == OP_AND || op == OP_OR || op == OP_EOR;
    wire cin = (op == OP_ADC || op == OP_SBC) && flags[F_C];
    wire [8:0] sum = is_sub ? {1'b0, ra} - {1'b0, rb} - {8'h00, cin}
        : {1'b0, ra} + {1'b0, rb} + {8'h00, cin};
    wire [4:0] nib = is_sub
        ? {1'b0, ra[3:0]} - {1'b0, rb[3:0]} - {4'h0, cin}
        : {1'b0, ra[3:0]} + {1'b0, rb[3:0]} + {4'h0, cin};
    wire ovf = is_sub ? (ra[7] & ~rb[7] & ~sum[7] | ~ra[7] & rb[7] & sum[7])
        : (ra[7] & rb[7] & ~sum[7] | ~ra[7] & ~rb[7] & sum[7]);
    wire [7:0] lres = op == OP_AND ? (ra & rb)
        : op == OP_OR ? (ra | rb) : (ra ^ rb);
    wire [7:0] res8 = is_arith ? sum[7:0] : lres;
    wire [15:0] adiw = wa + {10'h000, UOP.imm[5:0]};
    wire [15:0] prod = ra * rb;
    wire [7:0] bmask = 8'h01 << UOP.imm[2:0];
    wire [7:0] bit_load_instr = (ra & ~bmask) | (flags[F_T] ? bmask : 8'h00);

    // ------------------------------------------------------------
    // data address and stack
    // ------------------------------------------------------------
    wire is_ptr = op == OP_LD || op == OP_ST;
    wire [15:0] pinc = ptr_val + 16'h0001;
    wire [15:0] pdec = ptr_val - 16'h0001;
    wire [15:0] ea_ptr = UOP.am == AM_DISP ? ptr_val + UOP.imm
        : UOP.am == AM_PREDEC ? pdec : ptr_val; // [RL6]
    // direct i/o reaches only 64 bytes above the registers
    wire [15:0] ea_io = IO_BASE + {10'h000, UOP.imm[5:0]}; // [RL8] [RL9]
    wire [15:0] ea = is_ptr ? ea_ptr
        : (op == OP_IN || op == OP_OUT) ? ea_io
        : op == OP_PUSH ? stk_ptr
        : op == OP_POP ? stk_ptr + 16'h0001 : UOP.imm;
    wire is_ld = op == OP_LD || op == OP_LDS || op == OP_IN ||
        op == OP_POP;
    wire is_mem = is_ld || op == OP_ST || op == OP_STS || op == OP_OUT ||
        op == OP_PUSH;
    wire is_call = op == OP_CALL;
    wire is_ret = op == OP_SUB_RETURN || op == OP_IRQ_RETURN;
    wire [PC_W-1:0] ret_now = take_irq ? ir_pc : ir_pc + 15'h0001;
    wire mem_int = int_addr(dm.addr); // [RL7]
    wire [7:0] int_rd = dm.addr < IO_BASE ? rf[dm.addr[4:0]]
        : dm.addr == A_STK_LO ? stk_ptr[7:0]
        : dm.addr == A_STK_HI ? stk_ptr[15:8] : flags;
    wire [7:0] ld_data = mem_int ? int_rd : DM_RDATA;
    wire int_st = st == ST_MEM && !mem_ld && mem_int;

    // ------------------------------------------------------------
    // register file write port
    // ------------------------------------------------------------
    wire ptr_upd = is_ptr && UOP.am != AM_DISP; // [RL6]
    wire w8_run = is_arith || is_logic || op == OP_MOV || op == OP_LDI ||
        op == OP_BIT_LOAD;
    wire mem_rf = st == ST_MEM && (mem_ld || dm.addr < IO_BASE);
    wire w8_en = w8_run || mem_rf || st == ST_LPM;
    wire [4:0] w8_addr = st == ST_MEM && !mem_ld ? dm.addr[4:0]
        : st != ST_RUN ? mem_reg : UOP.rd;
    wire [7:0] w8_data = st == ST_LPM
        ? (lpm_odd ? PM_DATA[15:8] : PM_DATA[7:0])
        : st == ST_MEM ? (mem_ld ? ld_data : dm.wdata)
        : op == OP_MOV ? rb
        : op == OP_LDI ? UOP.imm[7:0]
        : op == OP_BIT_LOAD ? bit_load_instr : res8; // [RL12]
    wire w16 = op == OP_MOVW || op == OP_ADIW || op == OP_MUL || ptr_upd;
    wire [4:0] w16_addr = op == OP_MUL ? PAIR_MUL : ptr_upd ? pl : pa;
    wire [15:0] w16_data = op == OP_MOVW ? wb
        : op == OP_ADIW ? adiw
        : op == OP_MUL ? prod
        : UOP.am == AM_PREDEC ? pdec : pinc;

    // data is not reset; only control state needs a defined value
    always_ff @(posedge REF_CLK)
    begin
        if (w8_en) rf[w8_addr] <= w8_data; // [RL2] [RL3] [RL4]
        if (w16)
        begin
            rf[w16_addr] <= w16_data[7:0]; // [RL4]
            rf[w16_addr | 5'h01] <= w16_data[15:8];
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        case (st)
            ST_RUN:
            begin
                if (take_irq || is_call) next_st = ST_PUSH;
                else if (is_ret) next_st = ST_POP1;
                else if (is_mem) next_st = ST_MEM;
                else if (op == OP_LPM) next_st = ST_LPM;
            end
            ST_POP1: next_st = ST_POP2;
            default: next_st = ST_RUN;
        endcase
    end

    wire jump = op == OP_JMP || st == ST_PUSH || st == ST_POP2;
    wire [PC_W-1:0] jump_to = op == OP_JMP ? UOP.imm[PC_W-1:0]
        : st == ST_PUSH ? tgt : {pop_hi[6:0], DM_RDATA};
    wire adv = st == ST_RUN && !jump;

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pc <= PC_RST;
            pm_addr <= PC_RST;
            ir <= 16'h0000;
            ir_pc <= PC_RST;
            ir_valid <= 1'b0;
        end
        else if (jump)
        begin
            pc <= jump_to;
            pm_addr <= jump_to;
            ir_valid <= 1'b0;
        end
        else if (adv)
        begin
            ir <= PM_DATA; // [RL1]
            ir_pc <= pc;
            ir_valid <= 1'b1;
            pc <= pc + 15'h0001;
            pm_addr <= op == OP_LPM ? zptr[15:1] : pc + 15'h0001; // [RL5]
        end
        else if (st == ST_LPM) pm_addr <= pc;
    end

    // ------------------------------------------------------------
    // data bus request
    // ------------------------------------------------------------
    // call, return and irq stack traffic bypasses the internal map (push/pop use it): that stack must sit in sram
    always_comb
    begin
        next_dm = '{dm.addr, dm.wdata, 1'b0, 1'b0};
        if (take_irq || is_call)
            next_dm = '{stk_ptr, ret_now[7:0], 1'b1, 1'b0}; // [RL19] [RL22]
        else if (is_ret)
            next_dm = '{stk_ptr + 16'h0001, dm.wdata, 1'b0, 1'b1};
        else if (is_mem)
            next_dm = '{ea, ra, !is_ld && !int_addr(ea),
                is_ld && !int_addr(ea)};
        else if (st == ST_PUSH)
            next_dm = '{stk_ptr - 16'h0001, {1'b0, ret_pc[14:8]}, 1'b1,
                1'b0}; // [RL18]
        else if (st == ST_POP1)
            next_dm = '{stk_ptr + 16'h0002, dm.wdata, 1'b0, 1'b1};
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            dm <= '0;
            mem_ld <= 1'b0;
            mem_reg <= 5'h00;
            lpm_odd <= 1'b0;
            ret_pc <= PC_RST;
            tgt <= PC_RST;
            pop_hi <= 8'h00;
            ret_irq <= 1'b0;
        end
        else
        begin
            dm <= next_dm;
            pop_hi <= DM_RDATA;
            if (exec) mem_ld <= is_ld;
            if (exec) mem_reg <= UOP.rd;
            if (exec) lpm_odd <= zptr[0];
            if (exec) ret_irq <= op == OP_IRQ_RETURN;
            if (run) ret_pc <= ret_now;
            if (run) tgt <= take_irq ? IRQ_VEC : UOP.imm[PC_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // flags and stack pointer
    // ------------------------------------------------------------
    always_comb
    begin
        next_flags = flags;
        if (take_irq) next_flags[F_I] = 1'b0; // [RL11]
        if (is_arith || is_logic)
        begin
            next_flags[F_N] = res8[7]; // [RL15] [RL17]
            next_flags[F_Z] = res8 == 8'h00 &&
                (op != OP_SBC || flags[F_Z]); // [RL16]
            next_flags[F_V] = is_arith && ovf; // [RL15]
            if (is_arith) next_flags[F_C] = sum[8]; // [RL16]
            if (is_arith) next_flags[F_H] = nib[4]; // [RL13]
        end
        else if (op == OP_ADIW)
        begin
            next_flags[F_N] = adiw[15]; // [RL17]
            next_flags[F_Z] = adiw == 16'h0000;
            next_flags[F_V] = ~wa[15] & adiw[15];
            next_flags[F_C] = wa[15] & ~adiw[15];
        end
        else if (op == OP_MUL)
        begin
            next_flags[F_Z] = prod == 16'h0000; // [RL17]
            next_flags[F_C] = prod[15];
        end
        else if (op == OP_BIT_STORE) next_flags[F_T] = bst_bit; // [RL12]
        else if (op == OP_IRQ_ENABLE) next_flags[F_I] = 1'b1; // [RL11]
        else if (op == OP_IRQ_DISABLE) next_flags[F_I] = 1'b0; // [RL11]
        if (st == ST_POP2 && ret_irq) next_flags[F_I] = 1'b1; // [RL23]
        if (int_st && dm.addr == A_FLAGS) next_flags = dm.wdata;
        next_flags[F_S] = next_flags[F_N] ^ next_flags[F_V]; // [RL14]
    end

    always_comb
    begin
        next_stk = stk_ptr;
        if (op == OP_PUSH) next_stk = stk_ptr - 16'h0001; // [RL20]
        else if (op == OP_POP) next_stk = stk_ptr + 16'h0001; // [RL20]
        else if (st == ST_PUSH) next_stk = stk_ptr - 16'h0002; // [RL20]
        else if (st == ST_POP2) next_stk = stk_ptr + 16'h0002; // [RL23]
        else if (int_st && dm.addr == A_STK_LO)
            next_stk[7:0] = dm.wdata; // [RL21]
        else if (int_st && dm.addr == A_STK_HI)
            next_stk[15:8] = dm.wdata; // [RL21]
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st <= ST_RUN;
            flags <= FLAGS_RST; // [RL24]
            stk_ptr <= STK_RST; // [RL21]
            irq_ack <= 1'b0;
            hold <= 1'b0;
        end
        else
        begin
            st <= next_st;
            flags <= next_flags;
            stk_ptr <= next_stk;
            irq_ack <= take_irq;
            if (op == OP_IRQ_ENABLE || (st == ST_POP2 && ret_irq))
                hold <= 1'b1;
            else if (exec) hold <= 1'b0;
        end
    end

    assign PM_ADDR = pm_addr;
    assign INSTR = ir;
    assign INSTR_VALID = ir_valid;
    assign DM_REQ = dm;
    assign IRQ_ACK = irq_ack;
    assign FLAGS = flags;
    assign STACK_PTR = stk_ptr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sign_flag_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        flags[F_S] == (flags[F_N] ^ flags[F_V])) // [RL14]
        else $error("sign flag differs from n xor v");
    irq_gate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        irq_ack |-> $past(flags[F_I]) && !flags[F_I]) // [RL10]
        else $error("interrupt taken while disabled or enable kept");
    irq_return_instr_len_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        op == OP_IRQ_RETURN |-> ##1 st == ST_POP1 ##1 st == ST_POP2
        ##1 (flags[F_I] && stk_ptr == $past(stk_ptr, 3) + 16'h0002))
        else $error("interrupt return sequence wrong"); // [RL23]
    push_step_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        op == OP_PUSH |=> stk_ptr == $past(stk_ptr) - 16'h0001) // [RL20]
        else $error("push did not step stack pointer by one");
    call_step_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        op == OP_CALL |-> ##2 stk_ptr == $past(stk_ptr, 2) - 16'h0002)
        else $error("call did not step stack pointer by two"); // [RL20]
    alu_wb_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        op == OP_ADD |=> rf[$past(UOP.rd)] == $past(sum[7:0])) // [RL3]
        else $error("alu result not written back");
    fetch_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        adv |=> ir == $past(PM_DATA) && ir_pc == $past(pc)) // [RL1]
        else $error("fetch did not overlap execution");
    zero_flag_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        is_logic |=> flags[F_Z] == ($past(res8) == 8'h00)) // [RL16]
        else $error("zero flag wrong after logic op");
    bit_copy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        op == OP_BIT_STORE |=> flags[F_T] == $past(bst_bit)) // [RL12]
        else $error("copy bit not loaded");
    io_map_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (op == OP_IN || op == OP_OUT) |=>
        dm.addr >= IO_BASE && dm.addr < XIO_BASE) // [RL8]
        else $error("direct i/o left the i/o window");
endmodule : cfr_core

/* File: verif/cfr_mem_model.sv */
// partner model: program flash, decoder table, data sram
`timescale 1ns/100ps
module cfr_mem_model
    import cfr_pkg::*;
(
    input logic clk,
    input logic [PC_W-1:0] pm_addr,
    output logic [15:0] pm_data,
    input logic [15:0] instr,
    output cfr_uop_t uop,
    input cfr_dm_t dm_req,
    output logic [7:0] dm_rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    cfr_uop_t prog [0:63];
    logic [7:0] sram [0:1023];
    // ------------------------------------------------------------
    // flash, decoder and data bus
    // ------------------------------------------------------------
    // each flash word holds its own address, the table decodes it
    assign pm_data = {1'b0, pm_addr};
    assign uop = prog[instr[5:0]];
    // no read strobe: show inverse, so stale data cannot pass
    assign dm_rdata = dm_req.re ? sram[dm_req.addr[9:0]]
                                : ~sram[dm_req.addr[9:0]];
    // flags never appear here; only return bytes and data
    always @(posedge clk)
    begin
        if (dm_req.we)
        begin
            sram[dm_req.addr[9:0]] <= dm_req.wdata;
        end
    end
endmodule : cfr_mem_model

/* File: verif/cfr_core_tb.sv */
// testbench: runs a short program through the core datapath
`timescale 1ns/100ps
module cfr_core_tb
    import cfr_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk;
    logic nrst;
    logic irq_req;
    logic [PC_W-1:0] irq_vec;
    logic [PC_W-1:0] pm_addr;
    logic [15:0] pm_data;
    logic [15:0] instr;
    logic instr_valid;
    cfr_uop_t uop;
    cfr_dm_t dm_req;
    logic [7:0] dm_rdata;
    logic irq_ack;
    logic [7:0] flags;
    logic [15:0] stack_ptr;
    int errors = 0;
    int checks_done = 0;
    int wr_idx = 0;
    int ack_cnt = 0;
    logic [15:0] exp_addr [0:15] = '{16'h0103, 16'h0102, 16'h0101,
        16'h0200, 16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0205,
        16'h0206, 16'h0103, 16'h0102, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF};
    logic [15:0] exp_data [0:15] = '{16'h0080, 16'h0009, 16'h0000,
        16'h0080, 16'h0011, 16'h0042, 16'h0012, 16'h0003, 16'h002A,
        16'h0060, 16'h000F, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF};

    cfr_core u_cfr_core (
        .REF_CLK(ref_clk),
        .NRST(nrst),
        .PM_ADDR(pm_addr),
        .PM_DATA(pm_data),
        .INSTR(instr),
        .INSTR_VALID(instr_valid),
        .UOP(uop),
        .DM_REQ(dm_req),
        .DM_RDATA(dm_rdata),
        .IRQ_REQ(irq_req),
        .IRQ_VEC(irq_vec),
        .IRQ_ACK(irq_ack),
        .FLAGS(flags),
        .STACK_PTR(stack_ptr)
    );

    cfr_mem_model u_cfr_mem_model (
        .clk(ref_clk),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .instr(instr),
        .uop(uop),
        .dm_req(dm_req),
        .dm_rdata(dm_rdata)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #2 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic put(input int idx, input cfr_op_t op,
        input logic [4:0] rd, input logic [4:0] rr, input logic [15:0] imm);
        cfr_uop_t u;
        u = '0;
        u.op = op;
        u.rd = rd;
        u.rr = rr;
        u.imm = imm;
        u_cfr_mem_model.prog[idx] = u;
    endtask : put

    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // bus and interrupt monitor
    // ------------------------------------------------------------
    // every external write checked in order: push, call, sts, irq entry
    always @(posedge ref_clk)
    begin
        if (nrst && dm_req.we === 1'b1)
        begin
            check(dm_req.addr, exp_addr[wr_idx[3:0]]);
            check({8'h00, dm_req.wdata}, exp_data[wr_idx[3:0]]);
            wr_idx++;
        end
        if (irq_ack === 1'b1)
        begin
            ack_cnt++;
            check({8'h00, flags}, 16'h0060);
            irq_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        // request held high from the start: blocked until enable set
        irq_req = 1'b1;
        irq_vec = 15'h001E;
        for (int i = 0; i < 64; i++)
        begin
            put(i, OP_NOP, 5'h00, 5'h00, 16'h0000);
        end
        put(0, OP_LDI, 5'h10, 5'h00, 16'h007F);
        put(1, OP_LDI, 5'h11, 5'h00, 16'h0001);
        put(2, OP_ADD, 5'h10, 5'h11, 16'h0000);
        put(3, OP_LDI, 5'h12, 5'h00, 16'h0003);
        put(4, OP_LDI, 5'h13, 5'h00, 16'h0001);
        put(5, OP_OUT, 5'h12, 5'h00, 16'h003D);
        put(6, OP_OUT, 5'h13, 5'h00, 16'h003E);
        put(7, OP_PUSH, 5'h10, 5'h00, 16'h0000);
        put(8, OP_CALL, 5'h00, 5'h00, 16'h000C);
        put(9, OP_POP, 5'h14, 5'h00, 16'h0000);
        put(10, OP_STS, 5'h14, 5'h00, 16'h0200);
        put(11, OP_JMP, 5'h00, 5'h00, 16'h0020);
        put(12, OP_SUB_RETURN, 5'h00, 5'h00, 16'h0000);
        put(13, OP_IRQ_ENABLE, 5'h00, 5'h00, 16'h0000);
        put(15, OP_JMP, 5'h00, 5'h00, 16'h000F);
        put(30, OP_IRQ_RETURN, 5'h00, 5'h00, 16'h0000);
        // datapath block; results leave through stores to 0x0201..
        put(32, OP_AND, 5'h10, 5'h11, 16'h0000);
        put(33, OP_BIT_STORE, 5'h14, 5'h00, 16'h0007);
        put(34, OP_BIT_LOAD, 5'h11, 5'h00, 16'h0004);
        put(35, OP_MUL, 5'h11, 5'h12, 16'h0000);
        put(36, OP_MOVW, 5'h02, 5'h00, 16'h0000);
        put(37, OP_ADIW, 5'h02, 5'h00, 16'h000F);
        put(38, OP_LDI, 5'h1A, 5'h00, 16'h0011);
        put(39, OP_LDI, 5'h1B, 5'h00, 16'h0000);
        put(40, OP_LD, 5'h15, 5'h00, 16'h0000);
        u_cfr_mem_model.prog[40].am = AM_POSTINC;
        put(41, OP_STS, 5'h15, 5'h00, 16'h0201);
        put(42, OP_STS, 5'h02, 5'h00, 16'h0202);
        put(43, OP_STS, 5'h1A, 5'h00, 16'h0203);
        put(44, OP_IN, 5'h16, 5'h00, 16'h003D);
        put(45, OP_STS, 5'h16, 5'h00, 16'h0204);
        put(46, OP_LDI, 5'h1E, 5'h00, 16'h0054);
        put(47, OP_LDI, 5'h1F, 5'h00, 16'h0000);
        put(48, OP_LPM, 5'h17, 5'h00, 16'h0000);
        put(49, OP_STS, 5'h17, 5'h00, 16'h0205);
        // request still pending: the clear must run before it is taken
        put(50, OP_IRQ_ENABLE, 5'h00, 5'h00, 16'h0000);
        put(51, OP_IRQ_DISABLE, 5'h00, 5'h00, 16'h0000);
        put(52, OP_IN, 5'h18, 5'h00, 16'h003F);
        put(53, OP_STS, 5'h18, 5'h00, 16'h0206);
        put(54, OP_JMP, 5'h00, 5'h00, 16'h000D);
        repeat (8) @(posedge ref_clk);
        check(stack_ptr, STK_RST);
        check({8'h00, flags}, 16'h0000);
        check({15'h0000, instr_valid}, 16'h0000);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({15'h0000, instr_valid}, 16'h0001);
        check({1'b0, pm_addr}, 16'h0001);
        check(instr, 16'h0000);
        repeat (148) @(posedge ref_clk);
        check(16'(wr_idx), 16'h000C);
        check(16'(ack_cnt), 16'h0001);
        check(stack_ptr, 16'h0103);
        check({8'h00, flags}, 16'h00E0);
        give_verdict();
    end

    // hang guard, well past the expected run length
    initial
    begin
        #4000;
        errors++;
        give_verdict();
    end
endmodule : cfr_core_tb
